// file: tb/dbgs_host.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural debug host. It only ever pulls the line low, so a released line reads high through the pull-up.
module dbgs_host (
  input  wire logic clk,
  output logic      host_low
);
  initial host_low = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic send_byte(input logic [7:0] d, input int bd);
    logic [9:0] fr;
    fr = {1'b1, d, 1'b0};
    for (int i = 0; i < dbgs_pkg::FRAME_BITS; i++) begin
      host_low = ~fr[i];
      repeat (bd) @(negedge clk);
    end
  endtask

  // The caller picks the rate, so slow, recommended and too-fast rates can all be tried.
  task automatic sync(input int bd);
    send_byte(dbgs_pkg::SYNC_CHAR, bd);
  endtask

  task automatic hold_low(input int n);
    host_low = 1'b1;
    repeat (n) @(negedge clk);
    host_low = 1'b0;
    repeat (20) @(negedge clk);
  endtask
endmodule // dbgs_host
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((e) !== (g)) begin n_fail++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  logic       clk;
  logic       reset;
  logic       stop_mode;
  logic       rx_ready;
  logic       tx_valid;
  logic [7:0] tx_data;
  logic       host_low;
  logic       line;
  logic       debug_pin_out;
  logic       debug_pin_oe;
  logic       sys_reset_req;
  logic       locked;
  logic       rx_valid;
  logic [7:0] rx_data;
  logic       rx_overrun;
  logic       tx_ready;
  int         n_fail    = 0;
  int         tests_run = 0;
  int         n_ovr     = 0;

  assign line = (debug_pin_oe ? debug_pin_out : 1'b1) & ~host_low;

  dbgs_top i_dbgs_top (
    .clk(clk), .reset(reset), .debug_pin_in(line), .debug_pin_out(debug_pin_out),
    .debug_pin_oe(debug_pin_oe), .stop_mode(stop_mode), .sys_reset_req(sys_reset_req),
    .locked(locked), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .rx_overrun(rx_overrun), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready)
  );
  dbgs_host i_dbgs_host (.clk(clk), .host_low(host_low));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(negedge clk) if (rx_overrun === 1'b1) n_ovr <= n_ovr + 1;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // The trailing idle cycle keeps two calls in a row from raising rx_ready in the step that lowered it.
  task automatic recv(input logic [7:0] e);
    int k;
    k = 0;
    while (rx_valid !== 1'b1 && k < 200) begin
      @(negedge clk);
      k++;
    end
    `CHK("rx_valid", 1'b1, rx_valid)
    `CHK("rx_data", e, rx_data)
    rx_ready = 1'b1;
    @(negedge clk);
    rx_ready = 1'b0;
    @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_idle;
    `CHK("idle outs", 6'b100000, {debug_pin_out, debug_pin_oe, locked, rx_valid, tx_ready, sys_reset_req})
  endtask

  // Three cycles a bit is faster than the detector accepts, so no lock may follow.
  task automatic t_too_fast;
    i_dbgs_host.sync(3);
    repeat (10) @(negedge clk);
    `CHK("locked fast", 1'b0, locked)
  endtask

  task automatic t_sync_rx;
    i_dbgs_host.sync(8);
    `CHK("locked", 1'b1, locked)
    `CHK("sync kept back", 1'b0, rx_valid)
    i_dbgs_host.send_byte(8'ha5, 8);
    recv(8'ha5);
  endtask

  // Back-to-back bytes with the reader stalled: two are held, the third is dropped.
  task automatic t_buffer;
    i_dbgs_host.send_byte(8'h11, 8);
    i_dbgs_host.send_byte(8'h22, 8);
    i_dbgs_host.send_byte(8'h33, 8);
    repeat (6) @(negedge clk);
    `CHK("overruns", 1, n_ovr)
    recv(8'h11);
    recv(8'h22);
    @(negedge clk);
    `CHK("drained", 1'b0, rx_valid)
  endtask

  task automatic t_tx(input logic [7:0] d);
    logic [9:0] fr;
    int         k;
    fr = {1'b1, d, 1'b0};
    k = 0;
    tx_data = d;
    tx_valid = 1'b1;
    while (tx_ready !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    `CHK("tx ready", 1'b1, tx_ready)
    @(negedge clk);
    tx_valid = 1'b0;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 10; i++) begin
      `CHK("tx line", fr[i], line)
      `CHK("tx oe", 1'b1, debug_pin_oe)
      repeat (8) @(negedge clk);
    end
    `CHK("tx oe end", 1'b0, debug_pin_oe)
    `CHK("tx out idle", 1'b1, debug_pin_out)
  endtask

  task automatic t_break;
    i_dbgs_host.hold_low(100);
    `CHK("locked brk", 1'b0, locked)
    i_dbgs_host.sync(4);
    `CHK("locked div4", 1'b1, locked)
    i_dbgs_host.send_byte(8'hc3, 4);
    recv(8'hc3);
    i_dbgs_host.hold_low(60);
    `CHK("locked brk2", 1'b0, locked)
    i_dbgs_host.sync(512);
    `CHK("locked div512", 1'b1, locked)
    i_dbgs_host.send_byte(8'h5a, 512);
    recv(8'h5a);
  endtask

  task automatic t_stop;
    i_dbgs_host.host_low = 1'b1;
    repeat (8) @(negedge clk);
    `CHK("req run", 1'b0, sys_reset_req)
    stop_mode = 1'b1;
    repeat (3) @(negedge clk);
    `CHK("req stop", 1'b1, sys_reset_req)
    i_dbgs_host.host_low = 1'b0;
    repeat (8) @(negedge clk);
    `CHK("req high", 1'b0, sys_reset_req)
    stop_mode = 1'b0;
  endtask

  // A reset in mid-run drops the rate, so the host has to send the sync character again.
  task automatic t_reset_again;
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    t_idle();
    i_dbgs_host.sync(8);
    `CHK("locked rst", 1'b1, locked)
    i_dbgs_host.send_byte(8'h96, 8);
    recv(8'h96);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    reset = 1'b1;
    stop_mode = 1'b0;
    rx_ready = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    repeat (20) @(negedge clk);
    reset = 1'b0;
    t_idle();
    t_too_fast();
    t_sync_rx();
    t_buffer();
    t_tx(8'h3c);
    t_tx(8'hc5);
    t_break();
    t_stop();
    t_reset_again();
    print_verdict();
  end

  // The whole sequence needs about eleven thousand cycles.
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire

// file: verilog/dbgs_buf.sv
`timescale 1ns/1ps
`default_nettype none
// Two-entry skid buffer; the outputs come straight from flip-flops.
module dbgs_buf (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       in_valid,
  input  wire logic [7:0] in_data,
  output logic            in_ready,
  output logic            out_valid,
  input  wire logic       out_ready,
  output logic [7:0]      out_data
);
  logic       out_valid_ff;
  logic [7:0] out_data_ff;
  logic       skid_valid_ff;
  logic [7:0] skid_data_ff;
  logic       nxt_out_valid;
  logic [7:0] nxt_out_data;
  logic       nxt_skid_valid;
  logic [7:0] nxt_skid_data;

  assign in_ready  = !skid_valid_ff;
  assign out_valid = out_valid_ff;
  assign out_data  = out_data_ff;

  always_comb begin
    nxt_out_valid  = out_valid_ff;
    nxt_out_data   = out_data_ff;
    nxt_skid_valid = skid_valid_ff;
    nxt_skid_data  = skid_data_ff;
    if (!out_valid_ff || out_ready) begin
      if (skid_valid_ff) begin
        nxt_out_valid  = 1'b1;
        nxt_out_data   = skid_data_ff;
        nxt_skid_valid = in_valid;
        nxt_skid_data  = in_data;
      end else begin
        nxt_out_valid  = in_valid;
        nxt_out_data   = in_valid ? in_data : out_data_ff;
      end
    end else if (in_valid && !skid_valid_ff) begin
      nxt_skid_valid = 1'b1;
      nxt_skid_data  = in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      out_valid_ff  <= 1'b0;
      out_data_ff   <= 8'h00;
      skid_valid_ff <= 1'b0;
      skid_data_ff  <= 8'h00;
    end else begin
      out_valid_ff  <= nxt_out_valid;
      out_data_ff   <= nxt_out_data;
      skid_valid_ff <= nxt_skid_valid;
      skid_data_ff  <= nxt_skid_data;
    end
  end
endmodule // dbgs_buf
`default_nettype wire

// file: verilog/dbgs_pkg.sv
`default_nettype none
package dbgs_pkg;
  localparam int unsigned     DATA_BITS  = 8;
  localparam int unsigned     LOW_BITS   = 8;
  localparam int unsigned     FRAME_BITS = 10;
  localparam int unsigned     MIN_DIV    = 4;
  localparam int unsigned     MAX_DIV    = 512;
  localparam int unsigned     BREAK_BITS = 9;
  localparam int unsigned     CNT_W      = 13;
  localparam int unsigned     DIV_W      = 10;
  localparam int unsigned     RUN_W      = 14;
  localparam int unsigned     GUARD_W    = 3;
  localparam logic [7:0]      SYNC_CHAR  = 8'h80;
  localparam logic [CNT_W-1:0] MEAS_MIN  = 13'h0020;
  localparam logic [CNT_W-1:0] MEAS_MAX  = 13'h1007;
  localparam logic [CNT_W-1:0] MEAS_SAT  = 13'h1fff;
  localparam logic [CNT_W-1:0] ROUND_ADD = 13'h0004;
  localparam int unsigned     DIV_LSB    = 3;

  typedef enum logic [2:0] {
    ST_HUNT    = 3'b000,
    ST_MEASURE = 3'b001,
    ST_IDLE    = 3'b011,
    ST_START   = 3'b010,
    ST_DATA    = 3'b110,
    ST_STOP    = 3'b111
  } dbgs_state_e;
endpackage
`default_nettype wire

// file: verilog/dbgs_top.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Each character is one low start bit, eight data bits least significant first, and one high stop bit.
// - After any reset the unit does nothing until a character starts arriving on the line.
// - The low run of start bit plus seven low data bits of the sync character is timed and sets the divider.
// - Measurement and bit timing both count system-clock cycles.
// - Bit times up to 512 clock cycles are measured without the counter overflowing.
// - Bit times down to four clock cycles are still accepted on clean signals.
// - A line held low for nine or more bit times is a break and drops the measured rate.
// - After a break the host sends the sync character again and the rate is measured anew.
// - A low debug pin while the device is in stop mode requests a full system reset.
module dbgs_top (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       debug_pin_in,
  output logic            debug_pin_out,
  output logic            debug_pin_oe,
  input  wire logic       stop_mode,
  output logic            sys_reset_req,
  output logic            locked,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output logic [7:0]      rx_data,
  output logic            rx_overrun,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready
);
  localparam int unsigned CW = dbgs_pkg::CNT_W;
  localparam int unsigned DW = dbgs_pkg::DIV_W;
  localparam int unsigned RW = dbgs_pkg::RUN_W;

  function automatic logic [CW-1:0] bit_reload(input logic [DW-1:0] div);
    bit_reload = CW'({3'b000, div} - 13'h0001);
  endfunction

  function automatic logic [RW-1:0] break_limit(input logic [DW-1:0] div);
    break_limit = RW'({4'h0, div} * 14'(dbgs_pkg::BREAK_BITS));
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and echo guard.
  logic                pin_meta_ff;
  logic                pin_sync_ff;
  logic                pin_del_ff;
  logic [dbgs_pkg::GUARD_W-1:0] echo_ff;
  logic                line_fall;
  logic                guard;

  always_ff @(posedge clk) begin
    if (reset) begin
      pin_meta_ff <= 1'b1;
      pin_sync_ff <= 1'b1;
      pin_del_ff  <= 1'b1;
      echo_ff     <= '0;
    end else begin
      pin_meta_ff <= debug_pin_in;
      pin_sync_ff <= pin_meta_ff;
      pin_del_ff  <= pin_sync_ff;
      echo_ff     <= {echo_ff[dbgs_pkg::GUARD_W-2:0], debug_pin_oe};
    end
  end

  // Our own drive comes back through the synchroniser, so it is ignored for a few cycles after release.
  assign guard     = debug_pin_oe | (|echo_ff);
  assign line_fall = pin_del_ff & ~pin_sync_ff & ~guard;

  ////////////////////////////////////////////////////////////////////////////////
  // Receiver, rate detector and break detector.
  dbgs_pkg::dbgs_state_e state_ff, nxt_state;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic [DW-1:0] div_ff, nxt_div;
  logic          locked_ff, nxt_locked;
  logic [RW-1:0] run_ff, nxt_run;
  logic [2:0]    bits_ff, nxt_bits;
  logic [7:0]    shift_ff, nxt_shift;
  logic          push, overrun_ff, nxt_overrun, sysrst_ff, nxt_sysrst;
  logic          buf_ready, tx_take;
  logic [CW-1:0] meas_round;

  assign meas_round = cnt_ff + dbgs_pkg::ROUND_ADD;

  always_comb begin
    nxt_state   = state_ff;
    nxt_cnt     = cnt_ff;
    nxt_div     = div_ff;
    nxt_locked  = locked_ff;
    nxt_bits    = bits_ff;
    nxt_shift   = shift_ff;
    nxt_run     = run_ff;
    push        = 1'b0;
    unique case (state_ff)
      dbgs_pkg::ST_HUNT: begin
        if (line_fall) begin
          nxt_state = dbgs_pkg::ST_MEASURE;
          nxt_cnt   = 13'h0001;
        end
      end
      dbgs_pkg::ST_MEASURE: begin
        if (!pin_sync_ff) begin
          if (cnt_ff != dbgs_pkg::MEAS_SAT) begin
            nxt_cnt = cnt_ff + 13'h0001;
          end
        end else if (cnt_ff >= dbgs_pkg::MEAS_MIN && cnt_ff <= dbgs_pkg::MEAS_MAX) begin
          nxt_div    = meas_round[CW-1:dbgs_pkg::DIV_LSB];
          nxt_locked = 1'b1;
          nxt_state  = dbgs_pkg::ST_IDLE;
        end else begin
          nxt_state = dbgs_pkg::ST_HUNT;
        end
      end
      dbgs_pkg::ST_IDLE: begin
        if (line_fall && !tx_take) begin
          nxt_state = dbgs_pkg::ST_START;
          // One less than half a bit puts the start sample mid-bit, which matters most at four clocks a bit.
          nxt_cnt   = CW'(div_ff >> 1) - 13'h0001;
        end
      end
      dbgs_pkg::ST_START: begin
        if (cnt_ff == '0) begin
          nxt_state = pin_sync_ff ? dbgs_pkg::ST_IDLE : dbgs_pkg::ST_DATA;
          nxt_cnt   = bit_reload(div_ff);
          nxt_bits  = 3'h0;
        end else begin
          nxt_cnt = cnt_ff - 13'h0001;
        end
      end
      dbgs_pkg::ST_DATA: begin
        if (cnt_ff == '0) begin
          nxt_shift = {pin_sync_ff, shift_ff[7:1]};
          nxt_cnt   = bit_reload(div_ff);
          nxt_bits  = bits_ff + 3'h1;
          if (bits_ff == 3'h7) begin
            nxt_state = dbgs_pkg::ST_STOP;
          end
        end else begin
          nxt_cnt = cnt_ff - 13'h0001;
        end
      end
      dbgs_pkg::ST_STOP: begin
        if (cnt_ff == '0) begin
          push      = pin_sync_ff;
          nxt_state = dbgs_pkg::ST_IDLE;
        end else begin
          nxt_cnt = cnt_ff - 13'h0001;
        end
      end
      default: nxt_state = dbgs_pkg::ST_HUNT;
    endcase
    // The break counter runs beside the receiver so that it also catches a line stuck low mid-character.
    if (!locked_ff || pin_sync_ff || guard) begin
      nxt_run = '0;
    end else if (run_ff != {RW{1'b1}}) begin
      nxt_run = run_ff + 14'h0001;
    end
    if (locked_ff && run_ff >= break_limit(div_ff)) begin
      nxt_locked = 1'b0;
      nxt_state  = dbgs_pkg::ST_HUNT;
      nxt_run    = '0;
      push       = 1'b0;
    end
    nxt_overrun = push & ~buf_ready;
    nxt_sysrst  = stop_mode & ~pin_sync_ff & ~guard;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff   <= dbgs_pkg::ST_HUNT;
      cnt_ff     <= '0;
      div_ff     <= '0;
      locked_ff  <= 1'b0;
      bits_ff    <= 3'h0;
      shift_ff   <= 8'h00;
      run_ff     <= '0;
      overrun_ff <= 1'b0;
      sysrst_ff  <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      cnt_ff     <= nxt_cnt;
      div_ff     <= nxt_div;
      locked_ff  <= nxt_locked;
      bits_ff    <= nxt_bits;
      shift_ff   <= nxt_shift;
      run_ff     <= nxt_run;
      overrun_ff <= nxt_overrun;
      sysrst_ff  <= nxt_sysrst;
    end
  end

  // The line cannot be stalled, so a word arriving while both entries are full is flagged, and dropped unless rx_ready drains one that cycle.
  dbgs_buf u_buf (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (push),
    .in_data   (shift_ff),
    .in_ready  (buf_ready),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Transmitter; half duplex, it only starts while the receiver is idle and the line is high.
  logic                          tx_busy_ff, nxt_tx_busy;
  logic [dbgs_pkg::FRAME_BITS-1:0] tx_shift_ff, nxt_tx_shift;
  logic [3:0]                    tx_bits_ff, nxt_tx_bits;
  logic [CW-1:0]                 tx_cnt_ff, nxt_tx_cnt;
  logic                          tx_ready_ff, nxt_tx_ready;
  logic                          pin_out_ff, nxt_pin_out;

  assign tx_take = tx_valid & tx_ready_ff;

  always_comb begin
    nxt_tx_busy  = tx_busy_ff;
    nxt_tx_shift = tx_shift_ff;
    nxt_tx_bits  = tx_bits_ff;
    nxt_tx_cnt   = tx_cnt_ff;
    nxt_pin_out  = pin_out_ff;
    if (tx_take) begin
      nxt_tx_busy  = 1'b1;
      nxt_tx_shift = {1'b1, tx_data, 1'b0};
      nxt_pin_out  = 1'b0;
      nxt_tx_bits  = 4'h0;
      nxt_tx_cnt   = bit_reload(div_ff);
    end else if (tx_busy_ff) begin
      if (tx_cnt_ff == '0) begin
        nxt_tx_cnt   = bit_reload(div_ff);
        nxt_tx_bits  = tx_bits_ff + 4'h1;
        nxt_tx_shift = {1'b1, tx_shift_ff[dbgs_pkg::FRAME_BITS-1:1]};
        nxt_pin_out  = tx_shift_ff[1];
        if (tx_bits_ff == 4'(dbgs_pkg::FRAME_BITS - 1)) begin
          nxt_tx_busy = 1'b0;
          nxt_pin_out = 1'b1;
        end
      end else begin
        nxt_tx_cnt = tx_cnt_ff - 13'h0001;
      end
    end
    if (!nxt_locked) begin
      nxt_tx_busy = 1'b0;
      nxt_pin_out = 1'b1;
    end
    nxt_tx_ready = nxt_locked & ~nxt_tx_busy & ~tx_take & (nxt_state == dbgs_pkg::ST_IDLE) & pin_sync_ff & ~guard;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tx_busy_ff  <= 1'b0;
      tx_shift_ff <= '1;
      tx_bits_ff  <= 4'h0;
      tx_cnt_ff   <= '0;
      tx_ready_ff <= 1'b0;
      pin_out_ff  <= 1'b1;
    end else begin
      tx_busy_ff  <= nxt_tx_busy;
      tx_shift_ff <= nxt_tx_shift;
      tx_bits_ff  <= nxt_tx_bits;
      tx_cnt_ff   <= nxt_tx_cnt;
      tx_ready_ff <= nxt_tx_ready;
      pin_out_ff  <= nxt_pin_out;
    end
  end

  assign debug_pin_out = pin_out_ff;
  assign debug_pin_oe  = tx_busy_ff;
  assign tx_ready      = tx_ready_ff;
  assign locked        = locked_ff;
  assign rx_overrun    = overrun_ff;
  assign sys_reset_req = sysrst_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_idle_after_reset: assert property (@(posedge clk) reset |=> state_ff == dbgs_pkg::ST_HUNT && !locked_ff && !debug_pin_oe)
    else $error("unit not idle after reset");
  a_lock_divider: assert property (@(posedge clk) disable iff (reset)
    (state_ff == dbgs_pkg::ST_MEASURE && pin_sync_ff && cnt_ff >= dbgs_pkg::MEAS_MIN && cnt_ff <= dbgs_pkg::MEAS_MAX)
    |=> locked_ff && div_ff == $past(meas_round[CW-1:dbgs_pkg::DIV_LSB]))
    else $error("divider not loaded from measurement");
  a_measure_no_wrap: assert property (@(posedge clk) disable iff (reset)
    (state_ff == dbgs_pkg::ST_MEASURE && $past(state_ff) == dbgs_pkg::ST_MEASURE) |-> cnt_ff >= $past(cnt_ff))
    else $error("measurement counter wrapped");
  a_short_reject: assert property (@(posedge clk) disable iff (reset)
    (state_ff == dbgs_pkg::ST_MEASURE && pin_sync_ff && cnt_ff < 13'h0020 && !locked_ff) |=> !locked_ff)
    else $error("too short a sync accepted");
  a_break_unlock: assert property (@(posedge clk) disable iff (reset)
    (locked_ff && run_ff >= break_limit(div_ff)) |=> !locked_ff && state_ff == dbgs_pkg::ST_HUNT)
    else $error("break did not drop the rate");
  a_relock_path: assert property (@(posedge clk) disable iff (reset)
    $rose(locked_ff) |-> $past(state_ff) == dbgs_pkg::ST_MEASURE)
    else $error("lock without measurement");
  a_stop_reset: assert property (@(posedge clk) disable iff (reset)
    (stop_mode && !pin_sync_ff && !guard) |=> sys_reset_req)
    else $error("stop mode reset missed");
  a_tx_start_low: assert property (@(posedge clk) disable iff (reset)
    $rose(debug_pin_oe) |-> !debug_pin_out ##1 (!debug_pin_out)[*3])
    else $error("start bit not low");
  a_tx_stop_high: assert property (@(posedge clk) disable iff (reset)
    $fell(debug_pin_oe) && locked_ff |-> $past(debug_pin_out) && $past(tx_bits_ff) == 4'h9)
    else $error("frame did not end on stop bit");
  a_rx_push_stop: assert property (@(posedge clk) disable iff (reset)
    push |-> state_ff == dbgs_pkg::ST_STOP && pin_sync_ff && cnt_ff == '0)
    else $error("word pushed outside stop bit");
  a_bit_count: assert property (@(posedge clk) disable iff (reset)
    (state_ff == dbgs_pkg::ST_DATA && cnt_ff != '0) |=> cnt_ff == $past(cnt_ff) - 13'h0001)
    else $error("bit timer not counting clocks");

  c_lock: cover property (@(posedge clk) disable iff (reset) $rose(locked_ff));
  c_rx_word: cover property (@(posedge clk) disable iff (reset) push && buf_ready);
  c_break: cover property (@(posedge clk) disable iff (reset) $fell(locked_ff));
  c_tx_word: cover property (@(posedge clk) disable iff (reset) $fell(debug_pin_oe));
endmodule // dbgs_top
`default_nettype wire
